// ==== pkg/tprc_pkg.sv ====
package tprc_pkg;

   // Word and address widths of the interface area
   localparam int TPRC_DATA_W = 16;
   localparam int TPRC_ADDR_W = 6;
   localparam int TPRC_TASKS = 4;
   localparam int TPRC_CTRL_WORDS = 8;
   localparam int TPRC_CTRL_IDX_W = 3;

   // Area size per variant, in words
   localparam int TPRC_AREA_WORDS_4AX = 50;
   localparam int TPRC_AREA_WORDS_2AX = 30;

   // Area placement: origin word plus stride per unit number
   localparam logic [15:0] TPRC_AREA_ORIGIN = 16'h07D0;
   localparam logic [15:0] TPRC_AREA_STRIDE = 16'h000A;

   // Control word offsets (task 1), next task two words on
   localparam logic [5:0] TPRC_SEL_BASE = 6'h02;
   localparam logic [5:0] TPRC_RUN_BASE = 6'h03;
   localparam logic [5:0] TPRC_TASK_STEP = 6'h02;
   localparam logic [5:0] TPRC_CTRL_FIRST = 6'h02;
   localparam logic [5:0] TPRC_CTRL_LAST = 6'h09;

   // Status word offsets, one per task
   localparam logic [5:0] TPRC_STAT_T1 = 6'h17;
   localparam logic [5:0] TPRC_STAT_T2 = 6'h1B;
   localparam logic [5:0] TPRC_STAT_T3 = 6'h1E;
   localparam logic [5:0] TPRC_STAT_T4 = 6'h22;

   // Run control word bits
   localparam int TPRC_BIT_AUTO = 1;
   localparam int TPRC_BIT_CYCLE = 2;
   localparam int TPRC_BIT_PNUM_RD = 7;

   // Run status word bits
   localparam int TPRC_ST_AUTO = 2;
   localparam int TPRC_ST_EXEC = 4;
   localparam int TPRC_ST_DONE = 5;
   localparam int TPRC_ST_CSRX = 9;

   // Highest legal program number
   localparam logic [15:0] TPRC_PNUM_MAX = 16'h03E7;
   localparam logic [15:0] TPRC_WORD_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      TPRC_MANUAL = 2'b00,
      TPRC_READY = 2'b01,
      TPRC_RUN = 2'b10,
      TPRC_DONE = 2'b11
   } tprc_state_e;

   function automatic logic [5:0] tprc_stat_off(input int t);
      case (t)
         0: tprc_stat_off = TPRC_STAT_T1;
         1: tprc_stat_off = TPRC_STAT_T2;
         2: tprc_stat_off = TPRC_STAT_T3;
         default: tprc_stat_off = TPRC_STAT_T4;
      endcase
   endfunction : tprc_stat_off

   // Control word index in the bank: select words even, run words odd
   function automatic logic [2:0] tprc_ctrl_idx(input logic [5:0] off);
      logic [5:0] d;
      d = off - TPRC_CTRL_FIRST;
      tprc_ctrl_idx = d[2:0];
   endfunction : tprc_ctrl_idx

endpackage : tprc_pkg

// ==== rtl/tprc_edge.sv ====
`timescale 1ns/1ps
module tprc_edge
   import tprc_pkg::*;
#(
   parameter int N = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Levels and their edges
   input wire logic [N-1:0] level,
   output logic [N-1:0] rise,
   output logic [N-1:0] fall
);

   logic [N-1:0] prev_q;

   // Edges are judged here, not by the host's scan
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= level;
      end
   end

   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;

endmodule : tprc_edge

// ==== rtl/tprc_word_bank.sv ====
`timescale 1ns/1ps
module tprc_word_bank
   import tprc_pkg::*;
#(
   parameter int WORDS = 8,
   parameter int IDX_W = 3,
   parameter int W = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Write port
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   // Registered read port
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [W-1:0] rd_data,
   // All words, for the task logic
   output logic [WORDS*W-1:0] words
);

   logic [W-1:0] mem_q [WORDS];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= '0;
         end
         rd_data <= '0;
      end else begin
         if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
         end
         rd_data <= mem_q[rd_idx];
      end
   end

   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         words[i*W +: W] = mem_q[i];
      end
   end

endmodule : tprc_word_bank

// ==== rtl/tprc_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - Mode bit high is automatic; its rising edge stops manual axes.
// - Mode bit falling edge halts the program and stops all axes.
// - Cycle start rising edge starts the program in automatic mode; it runs while high.
// - Cycle start low stops the task's program.
// - While the read bit is high, a program number word up to 999 is loaded.
// - Automatic status bit is high in automatic mode, else low.
// - Execution status bit is high only while the program executes.
// - Completion status bit high once finished, low while not complete.
// - Cycle start received bit reports receipt, cleared while start is off.
// - Control bit edges are detected inside the device, not by the host.
// - Area placed by unit number; 50 words four-axis, 30 two-axis.
// - Completion clears the execution bit even with cycle start high.
module tprc_top
   import tprc_pkg::*;
#(
   parameter int TASKS = TPRC_TASKS,
   parameter int AREA_WORDS = TPRC_AREA_WORDS_4AX,
   parameter logic [15:0] AREA_ORIGIN = TPRC_AREA_ORIGIN,
   parameter logic [15:0] AREA_STRIDE = TPRC_AREA_STRIDE
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Interface area word access
   input wire logic [TPRC_ADDR_W-1:0] area_addr,
   input wire logic area_wr,
   input wire logic [TPRC_DATA_W-1:0] area_wdata,
   input wire logic area_rd,
   output logic [TPRC_DATA_W-1:0] area_rdata,
   output logic area_rvalid,
   // Unit number switch and resulting area placement
   input wire logic [3:0] unit_no,
   output logic [15:0] area_base,
   // Motion engine, one bit or word per task
   output logic [TASKS*TPRC_DATA_W-1:0] prog_number,
   output logic [TASKS-1:0] prog_start,
   output logic [TASKS-1:0] prog_stop,
   output logic [TASKS-1:0] prog_halt_all,
   output logic [TASKS-1:0] manual_decel,
   output logic [TASKS-1:0] prog_running,
   input wire logic [TASKS-1:0] prog_finished
);

   localparam int W = TPRC_DATA_W;

   // Area decode
   logic in_area;
   logic ctrl_hit;
   logic [TPRC_CTRL_IDX_W-1:0] ctrl_idx;
   logic ctrl_wr;
   logic [W-1:0] bank_rdata;
   logic [TPRC_CTRL_WORDS*W-1:0] bank_words;

   // Read path
   logic rd_ctrl_q;
   logic rvalid_q;
   logic [W-1:0] stat_rdata_q;
   logic [W-1:0] stat_sel;

   // Per task control levels and their edges
   logic [TASKS-1:0] mode_lvl;
   logic [TASKS-1:0] cycle_lvl;
   logic [TASKS-1:0] pnum_rd_lvl;
   logic [2*TASKS-1:0] edge_lvl;
   logic [2*TASKS-1:0] edge_rise;
   logic [2*TASKS-1:0] edge_fall;
   logic [TASKS-1:0] mode_rise;
   logic [TASKS-1:0] mode_fall;
   logic [TASKS-1:0] cycle_rise;

   // Per task status
   logic [W-1:0] stat_word [TASKS];
   logic [TASKS-1:0] auto_q;
   logic [TASKS-1:0] exec_q;
   logic [TASKS-1:0] done_q;
   logic [TASKS-1:0] csrx_q;
   logic [W-1:0] pnum_q [TASKS];
   logic [15:0] base_d;
   logic [15:0] base_q;

   // Accesses past the area belong to some other unit
   assign in_area = (32'(area_addr) < AREA_WORDS);
   assign ctrl_hit = in_area && (area_addr >= TPRC_CTRL_FIRST)
                     && (area_addr <= TPRC_CTRL_LAST);
   assign ctrl_idx = tprc_ctrl_idx(area_addr);
   // Status words are read-only; writes to them are dropped
   assign ctrl_wr = area_wr && ctrl_hit;

   tprc_word_bank #(
      .WORDS(TPRC_CTRL_WORDS),
      .IDX_W(TPRC_CTRL_IDX_W),
      .W(W)
   ) u_bank (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wr_en(ctrl_wr),
      .wr_idx(ctrl_idx),
      .wr_data(area_wdata),
      .rd_idx(ctrl_idx),
      .rd_data(bank_rdata),
      .words(bank_words)
   );

   // Status word selection for a read
   always_comb begin
      stat_sel = TPRC_WORD_ZERO;
      for (int t = 0; t < TASKS; t++) begin
         if (in_area && area_addr == tprc_stat_off(t)) begin
            stat_sel = stat_word[t];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ctrl_q <= 1'b0;
         rvalid_q <= 1'b0;
         stat_rdata_q <= '0;
      end else begin
         rd_ctrl_q <= area_rd && ctrl_hit;
         rvalid_q <= area_rd;
         stat_rdata_q <= stat_sel;
      end
   end

   // Both sources are flops; only the choice between them is late
   assign area_rdata = rd_ctrl_q ? bank_rdata : stat_rdata_q;
   assign area_rvalid = rvalid_q;

   // Area placement follows the unit number switch
   assign base_d = 16'(AREA_ORIGIN + 16'(unit_no) * AREA_STRIDE);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         base_q <= '0;
      end else begin
         base_q <= base_d;
      end
   end

   assign area_base = base_q;

   // Pull the control bits out of each task's run word
   always_comb begin
      for (int t = 0; t < TASKS; t++) begin
         mode_lvl[t] = bank_words[(2*t+1)*W + TPRC_BIT_AUTO];
         cycle_lvl[t] = bank_words[(2*t+1)*W + TPRC_BIT_CYCLE];
         pnum_rd_lvl[t] = bank_words[(2*t+1)*W + TPRC_BIT_PNUM_RD];
      end
   end

   assign edge_lvl = {cycle_lvl, mode_lvl};

   // A bit set and cleared between two host scans still counts here
   tprc_edge #(
      .N(2*TASKS)
   ) u_edge (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .level(edge_lvl),
      .rise(edge_rise),
      .fall(edge_fall)
   );

   assign mode_rise = edge_rise[TASKS-1:0];
   assign mode_fall = edge_fall[TASKS-1:0];
   assign cycle_rise = edge_rise[2*TASKS-1:TASKS];

   generate
      for (genvar t = 0; t < TASKS; t++) begin : g_task
         tprc_state_e state_q;
         tprc_state_e state_d;
         logic [W-1:0] sel_word;
         logic pnum_ok;
         logic start_d;
         logic stop_d;
         logic halt_d;
         logic decel_d;
         logic start_q;
         logic stop_q;
         logic halt_q;
         logic decel_q;

         assign sel_word = bank_words[2*t*W +: W];
         // Out-of-range numbers keep the last good one loaded
         assign pnum_ok = (sel_word <= TPRC_PNUM_MAX);

         always_comb begin
            state_d = state_q;
            start_d = 1'b0;
            stop_d = 1'b0;
            halt_d = 1'b0;
            decel_d = 1'b0;
            if (mode_fall[t]) begin
               state_d = TPRC_MANUAL;
               halt_d = 1'b1;
            end else begin
               case (state_q)
                  TPRC_MANUAL: begin
                     if (mode_rise[t]) begin
                        state_d = TPRC_READY;
                        decel_d = 1'b1;
                     end
                  end
                  TPRC_READY, TPRC_DONE: begin
                     if (cycle_rise[t]) begin
                        state_d = TPRC_RUN;
                        start_d = 1'b1;
                     end
                  end
                  TPRC_RUN: begin
                     if (prog_finished[t]) begin
                        state_d = TPRC_DONE;
                     end else if (!cycle_lvl[t]) begin
                        state_d = TPRC_READY;
                        stop_d = 1'b1;
                     end
                  end
                  default: begin
                     state_d = TPRC_MANUAL;
                  end
               endcase
            end
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               state_q <= TPRC_MANUAL;
               start_q <= 1'b0;
               stop_q <= 1'b0;
               halt_q <= 1'b0;
               decel_q <= 1'b0;
            end else begin
               state_q <= state_d;
               start_q <= start_d;
               stop_q <= stop_d;
               halt_q <= halt_d;
               decel_q <= decel_d;
            end
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               pnum_q[t] <= '0;
            end else if (pnum_rd_lvl[t] && pnum_ok) begin
               pnum_q[t] <= sel_word;
            end
         end

         // Status flags, all registered
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               auto_q[t] <= 1'b0;
               exec_q[t] <= 1'b0;
               done_q[t] <= 1'b0;
               csrx_q[t] <= 1'b0;
            end else begin
               auto_q[t] <= mode_lvl[t];
               exec_q[t] <= (state_d == TPRC_RUN);
               done_q[t] <= (state_d == TPRC_DONE);
               csrx_q[t] <= cycle_lvl[t];
            end
         end

         always_comb begin
            stat_word[t] = TPRC_WORD_ZERO;
            stat_word[t][TPRC_ST_AUTO] = auto_q[t];
            stat_word[t][TPRC_ST_EXEC] = exec_q[t];
            stat_word[t][TPRC_ST_DONE] = done_q[t];
            stat_word[t][TPRC_ST_CSRX] = csrx_q[t];
         end

         assign prog_number[t*W +: W] = pnum_q[t];
         assign prog_start[t] = start_q;
         assign prog_stop[t] = stop_q;
         assign prog_halt_all[t] = halt_q;
         assign manual_decel[t] = decel_q;
         assign prog_running[t] = exec_q[t];
      end
   endgenerate

endmodule : tprc_top

// ==== testbench/tprc_top_asserts.sv ====
`timescale 1ns/1ps
module tprc_top_asserts
   import tprc_pkg::*;
#(
   parameter int TASKS = TPRC_TASKS,
   parameter logic [15:0] AREA_ORIGIN = TPRC_AREA_ORIGIN,
   parameter logic [15:0] AREA_STRIDE = TPRC_AREA_STRIDE
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Area access
   input wire logic [TPRC_ADDR_W-1:0] area_addr,
   input wire logic area_rd,
   input wire logic [TPRC_DATA_W-1:0] area_rdata,
   input wire logic area_rvalid,
   input wire logic [3:0] unit_no,
   input wire logic [15:0] area_base,
   // Motion engine
   input wire logic [TASKS*TPRC_DATA_W-1:0] prog_number,
   input wire logic [TASKS-1:0] prog_start,
   input wire logic [TASKS-1:0] prog_stop,
   input wire logic [TASKS-1:0] prog_halt_all,
   input wire logic [TASKS-1:0] prog_running,
   input wire logic [TASKS-1:0] prog_finished
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_read_answer: assert property (area_rd |=> area_rvalid)
      else $error("read not answered one cycle later");
   a_rvalid_pulse: assert property (!area_rd |=> !area_rvalid)
      else $error("read valid without a read");
   a_unmapped_zero: assert property
      (area_rd && area_addr > 6'h22 |=> area_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_area_place: assert property
      (1'b1 |=> area_base == AREA_ORIGIN
         + {12'h000, $past(unit_no)} * AREA_STRIDE)
      else $error("area base wrong");
   a_start_runs: assert property ((prog_start & ~prog_running) == '0)
      else $error("start without execution flag");
   a_run_has_start: assert property
      ($rose(prog_running[0]) |-> prog_start[0])
      else $error("execution began without start");
   a_stop_idle: assert property
      (((prog_stop | prog_halt_all) & prog_running) == '0)
      else $error("still running after stop");
   a_finish_clears: assert property (|(prog_running & prog_finished) |=>
      (prog_running & $past(prog_running & prog_finished)) == '0)
      else $error("execution flag kept after completion");
   a_pnum_range: assert property (prog_number[15:0] <= 16'h03E7)
      else $error("program number out of range");

   c_start: cover property (prog_start[0]);
   c_halt: cover property (prog_halt_all[0]);
   c_finish: cover property (prog_running[0] && prog_finished[0]);
endmodule : tprc_top_asserts

bind tprc_top tprc_top_asserts #(.TASKS(TASKS), .AREA_ORIGIN(AREA_ORIGIN),
   .AREA_STRIDE(AREA_STRIDE)) chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
   .area_addr(area_addr), .area_rd(area_rd), .area_rdata(area_rdata),
   .area_rvalid(area_rvalid), .unit_no(unit_no), .area_base(area_base),
   .prog_number(prog_number), .prog_start(prog_start),
   .prog_stop(prog_stop), .prog_halt_all(prog_halt_all),
   .prog_running(prog_running), .prog_finished(prog_finished));

// ==== testbench/tprc_host_model.sv ====
`timescale 1ns/1ps
module tprc_host_model
   import tprc_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Area access
   output logic [TPRC_ADDR_W-1:0] area_addr,
   output logic area_wr,
   output logic [TPRC_DATA_W-1:0] area_wdata,
   output logic area_rd,
   input wire logic [TPRC_DATA_W-1:0] area_rdata,
   input wire logic area_rvalid
);
   initial begin
      area_addr = 6'h3F;
      area_wr = 1'b0;
      area_wdata = 16'h0000;
      area_rd = 1'b0;
   end

   // Released lines flip, so a stale value can never look valid
   // Each access first lets an edge pass, so back-to-back calls never
   // drive a line twice in one time step
   task wr(input logic [5:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      #1;
      area_addr = a;
      area_wdata = v;
      area_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      area_wr = 1'b0;
      area_addr = ~a;
      area_wdata = ~v;
   endtask : wr

   task rd(input logic [5:0] a, output logic [15:0] d, output logic ok);
      @(posedge ref_clk);
      #1;
      area_addr = a;
      area_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      area_rd = 1'b0;
      area_addr = ~a;
      ok = area_rvalid;
      d = area_rdata;
   endtask : rd

   // Mode, number, read pulse; start is left to the caller
   // Affected axes are taken as servo-locked before any start
   task load(input int t, input logic [15:0] p);
      wr(6'h03 + 6'(2 * t), 16'h0002);
      wr(6'h02 + 6'(2 * t), (p > 16'h03E7) ? 16'h03E7 : p);
      wr(6'h03 + 6'(2 * t), 16'h0082);
      wr(6'h03 + 6'(2 * t), 16'h0002);
   endtask : load
endmodule : tprc_host_model

// ==== testbench/tprc_top_bench.sv ====
`timescale 1ns/1ps
module tprc_top_bench
   import tprc_pkg::*;
;
   logic ref_clk, reset_n, aw, ar, rv, ok;
   logic [3:0] unit_no, pfin, ps, pst, pha, md, pr;
   logic [5:0] aa, rs, ss;
   logic [15:0] awd, rdt, ab, d, pv;
   logic [63:0] pn;
   logic [5:0] so [4] = '{6'h17, 6'h1B, 6'h1E, 6'h22};
   int errors = 0;
   int n_compared = 0;

   tprc_host_model host_u (.ref_clk(ref_clk), .area_addr(aa), .area_wr(aw),
      .area_wdata(awd), .area_rd(ar), .area_rdata(rdt), .area_rvalid(rv));
   tprc_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .area_addr(aa),
      .area_wr(aw), .area_wdata(awd), .area_rd(ar), .area_rdata(rdt),
      .area_rvalid(rv), .unit_no(unit_no), .area_base(ab),
      .prog_number(pn), .prog_start(ps), .prog_stop(pst),
      .prog_halt_all(pha), .manual_decel(md), .prog_running(pr),
      .prog_finished(pfin));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // Write, then wait until registered pulses and flags have landed
   task go(input logic [5:0] a, input logic [15:0] v);
      host_u.wr(a, v);
      tick(2);
   endtask : go

   task rdc(input logic [5:0] a, input logic [15:0] e);
      host_u.rd(a, d, ok);
      chk(16'(ok), 16'h0001);
      chk(d, e);
   endtask : rdc

   function automatic logic [15:0] sw(input logic a, x, dn, c);
      sw = 16'h0000;
      sw[TPRC_ST_AUTO] = a;
      sw[TPRC_ST_EXEC] = x;
      sw[TPRC_ST_DONE] = dn;
      sw[TPRC_ST_CSRX] = c;
   endfunction : sw

   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      wrap_up();
   end

   initial begin
      reset_n = 1'b0;
      unit_no = 4'h3;
      pfin = 4'h0;
      tick(5);
      chk({12'h000, ps | pst | pha | md | pr}, 16'h0000);
      reset_n = 1'b1;
      for (int t = 0; t < 4; t++) begin
         rs = 6'h03 + 6'(2 * t);
         ss = 6'h02 + 6'(2 * t);
         pv = 16'h0005 + 16'(t);
         // Pulses stand one cycle after the edge that follows the write
         host_u.wr(rs, 16'h0004);
         tick(1);
         chk(16'(ps[t]), 16'h0000);
         tick(1);
         host_u.wr(rs, 16'h0002);
         tick(1);
         chk(16'(md[t]), 16'h0001);
         tick(1);
         rdc(so[t], sw(1, 0, 0, 0));
         go(rs, 16'h0000);
         go(rs, 16'h0002);
         host_u.wr(ss, pv);
         go(rs, 16'h0082);
         chk(pn[t*16+:16], pv);
         go(ss, 16'h03E8);
         chk(pn[t*16+:16], pv);
         go(ss, 16'h03E7);
         chk(pn[t*16+:16], 16'h03E7);
         go(rs, 16'h0002);
         go(ss, 16'h0001);
         chk(pn[t*16+:16], 16'h03E7);
         host_u.wr(rs, 16'h0006);
         tick(1);
         chk(16'(ps[t]), 16'h0001);
         tick(1);
         rdc(so[t], sw(1, 1, 0, 1));
         pfin[t] = 1'b1;
         tick(1);
         pfin[t] = 1'b0;
         tick(1);
         rdc(so[t], sw(1, 0, 1, 1));
         chk(16'(pr[t]), 16'h0000);
         go(rs, 16'h0002);
         rdc(so[t], sw(1, 0, 1, 0));
         go(rs, 16'h0006);
         host_u.wr(rs, 16'h0002);
         tick(1);
         chk(16'(pst[t]), 16'h0001);
         tick(1);
         rdc(so[t], sw(1, 0, 0, 0));
         go(rs, 16'h0006);
         host_u.wr(rs, 16'h0000);
         tick(1);
         chk(16'(pha[t]), 16'h0001);
         tick(1);
         rdc(so[t], sw(0, 0, 0, 0));
         $display("task %0d done", t);
      end
      host_u.load(1, 16'h0FFF);
      tick(2);
      chk(pn[31:16], 16'h03E7);
      rdc(6'h02, 16'h0001);
      host_u.wr(6'h17, 16'hFFFF);
      rdc(6'h17, 16'h0000);
      rdc(6'h30, 16'h0000);
      chk(ab, 16'h07EE);
      $display("area test done");
      wrap_up();
   end
endmodule : tprc_top_bench
